// file: src/spm_pkg.sv
// constants, types and helpers for the serial protected memory
// Overview of operation
// RULE_01: modes 0 and 3, idle clock sampled at select
// RULE_02: master lowers idle-high clock before first bit
// RULE_03: bytes MSB first, sample rising, shift falling
// RULE_04: first byte is op-code, one per select
// RULE_05: decode set and clear write enable commands
// RULE_06: decode status read and status write commands
// RULE_07: decode memory read and memory write commands
// RULE_08: latch cleared at reset, gates every write
// RULE_09: finished write clears latch at deselect
// RULE_10: clear command drops latch, blocks writes
// RULE_11: status write never changes latch bit
// RULE_12: status layout: enable, protect bits, latch
// RULE_13: protect encoding selects protected upper ranges
// RULE_14: pin protect enable gates status writes
// RULE_15: array writes gated by latch and protect only
// RULE_16: 15-bit address, increments, wraps to zero
// RULE_17: each byte stored after its eighth clock
// RULE_18: protect pin sampled only at select
// RULE_19: read ignores input, streams incrementing addresses
// RULE_20: pause input freezes operation while clock low
// RULE_21: master waits after power-up before selecting
// RULE_22: deselected device ignores inputs, output floats
// RULE_23: output driven only while returning data
// RULE_24: protected byte dropped, address still advances
package spm_pkg;
   localparam int         ADDR_W        = 15;
   localparam int         MEM_DEPTH     = 32768;
   localparam logic [7:0] OP_SET_WE     = 8'h06;
   localparam logic [7:0] OP_CLR_WE     = 8'h04;
   localparam logic [7:0] OP_RD_STATUS  = 8'h05;
   localparam logic [7:0] OP_WR_STATUS  = 8'h01;
   localparam logic [7:0] OP_READ       = 8'h03;
   localparam logic [7:0] OP_WRITE      = 8'h02;
   localparam int         ST_PPE_BIT    = 7;
   localparam int         ST_BPH_BIT    = 3;
   localparam int         ST_BPL_BIT    = 2;
   localparam int         ST_WEL_BIT    = 1;
   localparam logic [14:0] PROT_QTR_BASE = 15'h6000;
   localparam logic [14:0] PROT_HALF_BASE = 15'h4000;
   localparam logic [1:0] BP_NONE       = 2'h0;
   localparam logic [1:0] BP_QTR        = 2'h1;
   localparam logic [1:0] BP_HALF       = 2'h2;
   localparam logic [2:0] BIT_LAST      = 3'h7;
   localparam logic [14:0] ADDR_ONE     = 15'h0001;
   localparam logic       PPE_RESET     = 1'b0;
   localparam logic [1:0] BP_RESET      = 2'h0;

   typedef struct packed {
      logic pin_protect_enable;
      logic block_protect_hi;
      logic block_protect_lo;
      logic write_enable_latch;
   } spm_status_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic wp_n;
      logic hold_n;
   } spm_pins_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA,
      ST_RDATA, ST_STATUS_RD, ST_STATUS_WR, ST_DONE
   } spm_state_t;

   // protected range check
   function automatic logic spm_is_protected(input logic [14:0] a, input logic [1:0] bp);
      case (bp)
         BP_NONE: spm_is_protected = 1'b0;
         BP_QTR:  spm_is_protected = (a >= PROT_QTR_BASE);
         BP_HALF: spm_is_protected = (a >= PROT_HALF_BASE);
         default: spm_is_protected = 1'b1;
      endcase
   endfunction

   // status byte assembly, unused bits zero
   function automatic logic [7:0] spm_status_byte(input spm_status_t s);
      logic [7:0] b;
      b = 8'h00;
      b[ST_PPE_BIT] = s.pin_protect_enable;
      b[ST_BPH_BIT] = s.block_protect_hi;
      b[ST_BPL_BIT] = s.block_protect_lo;
      b[ST_WEL_BIT] = s.write_enable_latch;
      return b;
   endfunction
endpackage

// file: src/spm_serial_mem.sv
// serial command interface of the protected byte memory
module spm_serial_mem
   import spm_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic cs_n_i,
   input  wire logic sck_i,
   input  wire logic si_i,
   input  wire logic wp_n_i,
   input  wire logic hold_n_i,
   output logic      so_o,
   output logic      so_oe_o
);

   spm_pins_t   pin_s1;
   spm_pins_t   pin_s2;
   logic        sck_prev;
   spm_state_t  state;
   spm_state_t  next_state;
   logic [2:0]  bit_cnt;
   logic [2:0]  next_bit_cnt;
   logic [7:0]  shreg;
   logic [7:0]  next_shreg;
   logic [14:0] addr;
   logic [14:0] next_addr;
   logic [7:0]  tx;
   logic [7:0]  next_tx;
   spm_status_t status;
   spm_status_t next_status;
   logic        mode3;
   logic        next_mode3;
   logic        wp_lat;
   logic        next_wp_lat;
   logic        paused;
   logic        next_paused;
   logic        wr_op;
   logic        next_wr_op;
   logic        rise_seen;
   logic        next_rise_seen;
   logic        drive;
   logic        next_drive;
   logic        next_so;
   logic        next_so_oe;
   logic        sel;
   logic        rise;
   logic        fall;
   logic        start;
   logic [7:0]  byte_in;
   logic        byte_done;
   logic        mem_we;
   logic        st_we;
   logic [14:0] rd_addr;
   logic [7:0]  mem [MEM_DEPTH];

   // pin synchronisers, no logic on first stage
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1   <= '1;
         pin_s2   <= '1;
         sck_prev <= 1'b1;
      end else begin
         pin_s1   <= {cs_n_i, sck_i, si_i, wp_n_i, hold_n_i};
         pin_s2   <= pin_s1;
         sck_prev <= pin_s2.sck;
      end
   end

   always_comb begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_shreg     = shreg;
      next_addr      = addr;
      next_tx        = tx;
      next_status    = status;
      next_mode3     = mode3;
      next_wp_lat    = wp_lat;
      next_wr_op     = wr_op;
      next_rise_seen = rise_seen;
      next_drive     = drive;
      next_so        = so_o;
      mem_we         = 1'b0;
      st_we          = 1'b0;
      rd_addr        = addr;
      sel            = !pin_s2.cs_n;
      // pause changes only while clock low
      next_paused    = pin_s2.sck ? paused : !pin_s2.hold_n; // see RULE_20
      rise           = pin_s2.sck && !sck_prev && !paused; // see RULE_20
      fall           = !pin_s2.sck && sck_prev && !paused;
      byte_in        = {shreg[6:0], pin_s2.si}; // see RULE_03
      byte_done      = rise && (bit_cnt == BIT_LAST);
      start          = 1'b0;
      if (paused) begin
         next_state = state;
      end else if (state == ST_IDLE) begin
         if (sel) begin
            start          = 1'b1;
            next_state     = ST_OPCODE; // see RULE_04
            next_bit_cnt   = 3'h0;
            next_mode3     = pin_s2.sck; // see RULE_01
            next_wp_lat    = pin_s2.wp_n; // see RULE_18
            next_wr_op     = 1'b0;
            next_rise_seen = 1'b0;
            next_drive     = 1'b0;
         end
      end else if (!sel) begin
         next_state = ST_IDLE; // see RULE_22
         next_drive = 1'b0;
         if (wr_op) begin
            next_status.write_enable_latch = 1'b0; // see RULE_09
         end
      end else begin
         if (rise) begin
            next_shreg     = byte_in;
            next_bit_cnt   = bit_cnt + 3'h1;
            next_rise_seen = 1'b1;
         end
         if (byte_done) begin
            case (state)
               ST_OPCODE: begin
                  case (byte_in)
                     OP_SET_WE: begin
                        next_status.write_enable_latch = 1'b1; // see RULE_05
                        next_state = ST_DONE;
                     end
                     OP_CLR_WE: begin
                        next_status.write_enable_latch = 1'b0; // see RULE_10
                        next_state = ST_DONE;
                     end
                     OP_RD_STATUS: begin
                        next_tx    = spm_status_byte(status); // see RULE_06
                        next_state = ST_STATUS_RD;
                     end
                     OP_WR_STATUS: begin
                        next_wr_op = status.write_enable_latch; // see RULE_08
                        next_state = status.write_enable_latch ? ST_STATUS_WR : ST_DONE;
                     end
                     OP_READ: begin
                        next_state = ST_ADDR_HI; // see RULE_07
                     end
                     OP_WRITE: begin
                        next_wr_op = status.write_enable_latch; // see RULE_08
                        next_state = status.write_enable_latch ? ST_ADDR_HI : ST_DONE;
                     end
                     default: begin
                        next_state = ST_DONE;
                     end
                  endcase
               end
               ST_ADDR_HI: begin
                  next_addr  = {byte_in[6:0], addr[7:0]}; // see RULE_16
                  next_state = ST_ADDR_LO;
               end
               ST_ADDR_LO: begin
                  if (wr_op) begin
                     next_addr  = {addr[14:8], byte_in};
                     next_state = ST_WDATA;
                  end else begin
                     rd_addr    = {addr[14:8], byte_in};
                     next_tx    = mem[rd_addr];
                     next_addr  = rd_addr + ADDR_ONE; // see RULE_19
                     next_state = ST_RDATA;
                  end
               end
               ST_WDATA: begin
                  mem_we    = !spm_is_protected(addr, {status.block_protect_hi,
                                                       status.block_protect_lo}); // see RULE_13, RULE_15
                  next_addr = addr + ADDR_ONE; // see RULE_24
               end
               ST_RDATA: begin
                  next_tx   = mem[addr]; // see RULE_19
                  next_addr = addr + ADDR_ONE;
               end
               ST_STATUS_RD: begin
                  next_tx = spm_status_byte(status);
               end
               ST_STATUS_WR: begin
                  if (!(status.pin_protect_enable && !wp_lat)) begin
                     st_we = 1'b1; // see RULE_14
                     next_status.pin_protect_enable = byte_in[ST_PPE_BIT]; // see RULE_12
                     next_status.block_protect_hi   = byte_in[ST_BPH_BIT];
                     next_status.block_protect_lo   = byte_in[ST_BPL_BIT]; // see RULE_11
                  end
                  next_state = ST_DONE;
               end
               default: begin
                  next_state = state;
               end
            endcase
         end
         // shift out on falling edge; idle-high clock's first fall skipped
         if (fall && (rise_seen || !mode3) &&
             (state == ST_RDATA || state == ST_STATUS_RD)) begin
            next_so    = tx[BIT_LAST - bit_cnt]; // see RULE_03
            next_drive = 1'b1; // see RULE_23
         end
      end
      next_so_oe = next_drive && !next_paused; // see RULE_23
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state     <= ST_IDLE;
         bit_cnt   <= 3'h0;
         shreg     <= 8'h00;
         addr      <= 15'h0000;
         tx        <= 8'h00;
         status    <= '{pin_protect_enable: PPE_RESET, block_protect_hi: BP_RESET[1],
                        block_protect_lo: BP_RESET[0], write_enable_latch: 1'b0};
         mode3     <= 1'b0;
         wp_lat    <= 1'b1;
         paused    <= 1'b0;
         wr_op     <= 1'b0;
         rise_seen <= 1'b0;
         drive     <= 1'b0;
         so_o      <= 1'b0;
         so_oe_o   <= 1'b0;
      end else begin
         state     <= next_state;
         bit_cnt   <= next_bit_cnt;
         shreg     <= next_shreg;
         addr      <= next_addr;
         tx        <= next_tx;
         status    <= next_status;
         mode3     <= next_mode3;
         wp_lat    <= next_wp_lat;
         paused    <= next_paused;
         wr_op     <= next_wr_op;
         rise_seen <= next_rise_seen;
         drive     <= next_drive;
         so_o      <= next_so;
         so_oe_o   <= next_so_oe;
      end
   end

   // array store right after eighth clock
   always_ff @(posedge clock_i) begin
      if (mem_we) begin
         mem[addr] <= byte_in; // see RULE_17
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   idle_float_a: assert property (state == ST_IDLE |-> !so_oe_o) // see RULE_22
      else $error("output driven while deselected");
   pause_float_a: assert property (paused |-> !so_oe_o) // see RULE_23
      else $error("output driven while paused");
   // latch, array, link and pause guards
   wel_set_a: assert property (byte_done && state == ST_OPCODE && byte_in == OP_SET_WE && sel // see RULE_05
                               |=> status.write_enable_latch && state == ST_DONE)
      else $error("set command did not set latch");
   wel_clear_a: assert property (byte_done && state == ST_OPCODE && byte_in == OP_CLR_WE && sel // see RULE_10
                                 |=> !status.write_enable_latch)
      else $error("clear command did not clear latch");
   wel_end_a: assert property (!paused && !sel && wr_op && state != ST_IDLE // see RULE_09
                               |=> !status.write_enable_latch ##1 !status.write_enable_latch)
      else $error("latch survived end of write");
   wel_kept_a: assert property (st_we |=> status.write_enable_latch == $past(status.write_enable_latch)) // see RULE_11
      else $error("status write changed latch");
   mem_gate_a: assert property (mem_we // see RULE_15
                                |-> status.write_enable_latch && state == ST_WDATA &&
                                !spm_is_protected(addr, {status.block_protect_hi, status.block_protect_lo}))
      else $error("array write not allowed");
   store_now_a: assert property (byte_done && sel && state == ST_WDATA && // see RULE_17
                                 !spm_is_protected(addr, {status.block_protect_hi, status.block_protect_lo})
                                 |-> mem_we)
      else $error("byte not stored on eighth clock");
   addr_step_a: assert property (byte_done && sel && (state == ST_WDATA || state == ST_RDATA) // see RULE_16
                                 |=> addr == $past(addr) + ADDR_ONE)
      else $error("address did not advance");
   addr_wrap_a: assert property (byte_done && sel && (state == ST_WDATA || state == ST_RDATA) && addr == '1 // see RULE_16
                                 |=> addr == '0)
      else $error("address did not wrap to zero");
   status_wp_a: assert property (byte_done && sel && state == ST_STATUS_WR && // see RULE_14
                                 status.pin_protect_enable && !wp_lat |-> !st_we ##1 $stable(status))
      else $error("status written while pin protected");
   wp_stable_a: assert property (state != ST_IDLE && state != ST_OPCODE |=> $stable(wp_lat)) // see RULE_18
      else $error("protect pin sample moved mid operation");
   mode_pick_a: assert property (start |=> mode3 == $past(pin_s2.sck)) // see RULE_01
      else $error("mode not taken at select");
   status_hold_a: assert property (state == ST_STATUS_RD && fall && sel && (rise_seen || !mode3) // see RULE_03
                                   |=> so_o == $past(tx[BIT_LAST - bit_cnt]) && drive)
      else $error("wrong status bit shifted out");
   so_edge_a: assert property ($changed(so_o) |-> $past(fall)) // see RULE_03
      else $error("output bit moved without clock fall");
   one_op_a: assert property (state == ST_DONE && sel && !paused |=> state == ST_DONE) // see RULE_04
      else $error("second op-code accepted in one select");
   oe_src_a: assert property ($rose(so_oe_o) |-> state == ST_RDATA || state == ST_STATUS_RD) // see RULE_23
      else $error("output enabled outside a read");
   idle_quiet_a: assert property (state == ST_IDLE && !sel // see RULE_22
                                  |=> state == ST_IDLE && $stable(status) && $stable(addr))
      else $error("deselected device changed state");
   pause_keep_a: assert property (paused && pin_s2.sck |=> paused) // see RULE_20
      else $error("pause changed while clock high");
   pause_freeze_a: assert property (paused |=> $stable(state) && $stable(bit_cnt) && $stable(addr)) // see RULE_20
      else $error("operation moved while paused");

   read_seen_c: cover property (state == ST_RDATA && byte_done);
   write_seen_c: cover property (mem_we);
   status_seen_c: cover property (st_we);
   pause_seen_c: cover property (paused && state == ST_RDATA);
   mode3_seen_c: cover property (start ##1 mode3);
endmodule

// file: test/spm_master_model.sv
// serial bus master model driving the memory pins
module spm_master_model (
   input  wire logic so_i,
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      si_o,
   output logic      hold_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam real HALF = 62.5;
   logic mode3 = 1'b0;

   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
      hold_n_o = 1'b1;
   end

   // select with the idle clock level giving the mode
   task automatic start(input logic m3);
      mode3 = m3;
      sck_o = m3;
      #HALF;
      cs_n_o = 1'b0;
      #HALF;
   endtask

   // one byte, msb first, sampled at the rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck_o = 1'b0;
         si_o = tx[i];
         #HALF;
         sck_o = 1'b1;
         rx[i] = so_i;
         #HALF;
      end
   endtask

   // deselect, clock parked, data line no longer held
   task automatic stop();
      sck_o = mode3;
      #HALF;
      cs_n_o = 1'b1;
      si_o = ~si_o;
      #(2 * HALF);
   endtask

   // pause with clock low, clock toggled while paused
   task automatic hold(input logic on);
      if (on) begin
         sck_o = 1'b0;
         #HALF;
         hold_n_o = 1'b0;
         #HALF;
         sck_o = 1'b1;
         #HALF;
         sck_o = 1'b0;
         #HALF;
      end else begin
         hold_n_o = 1'b1;
         #HALF;
      end
   endtask
endmodule

// file: test/test_spm_serial_mem.sv
// self-checking bench for the serial protected memory
module test_spm_serial_mem
   import spm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        wp_n  = 1'b1;
   logic        md    = 1'b0;
   wire logic   cs_n, sck, si, hold_n, so, so_oe;
   int          fail_count = 0;
   int          cmp_count  = 0;
   int          cyc        = 0;
   logic [7:0]  s, r, ex[3];
   logic [15:0] la[3] = '{16'h0000, 16'h4000, 16'h6000};
   wire logic   so_pin = so_oe ? so : 1'bz;

   spm_serial_mem dut (.clock_i(clock), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
      .wp_n_i(wp_n), .hold_n_i(hold_n), .so_o(so), .so_oe_o(so_oe));
   spm_master_model m (.so_i(so_pin), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .hold_n_o(hold_n));

   initial begin
      forever #5 clock = ~clock;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic fin();
      m.stop();
      chk("output floats deselected", {7'h00, so_oe}, 8'h00);
   endtask

   task automatic op(input logic [7:0] c);
      m.start(md);
      m.xfer(c, r);
      fin();
   endtask

   task automatic stat(output logic [7:0] v);
      m.start(md);
      m.xfer(OP_RD_STATUS, r);
      m.xfer(8'h00, v);
      fin();
   endtask

   task automatic wsr(input logic [7:0] v);
      op(OP_SET_WE);
      m.start(md);
      m.xfer(OP_WR_STATUS, r);
      m.xfer(v, r);
      fin();
   endtask

   task automatic mwr(input logic we, input logic [15:0] a, input logic [7:0] q[$]);
      if (we) begin
         op(OP_SET_WE);
      end
      m.start(md);
      m.xfer(OP_WRITE, r);
      m.xfer(a[15:8], r);
      m.xfer(a[7:0], r);
      foreach (q[i]) begin
         m.xfer(q[i], r);
      end
      fin();
   endtask

   task automatic mrd(input logic [15:0] a, input logic [7:0] q[$], input string nm);
      m.start(md);
      m.xfer(OP_READ, r);
      m.xfer(a[15:8], r);
      m.xfer(a[7:0], r);
      foreach (q[i]) begin
         m.xfer(OP_WRITE, r);
         chk(nm, r, q[i]);
      end
      fin();
   endtask

   task automatic set_wp(input logic v);
      @(posedge clock);
      #1;
      wp_n = v;
   endtask

   initial begin
      repeat (5) @(posedge clock);
      #1;
      rst_n = 1'b1;
      repeat (10) @(posedge clock);
      #1;
      stat(s);
      chk("status after reset", s, 8'h00);
      op(OP_SET_WE);
      stat(s);
      chk("latch set", s, 8'h02);
      m.start(md);
      m.xfer(OP_CLR_WE, r);
      m.xfer(OP_SET_WE, r);
      fin();
      stat(s);
      chk("one command per select", s, 8'h00);
      for (int bp = 0; bp < 4; bp++) begin
         wsr(8'(bp * 4));
         stat(s);
         chk("protect bits", s, 8'(bp * 4));
         for (int k = 0; k < 3; k++) begin
            mwr(1'b1, la[k], '{8'(16 + bp)});
            if (!(bp == 3 || (bp == 2 && k > 0) || (bp == 1 && k == 2))) begin
               ex[k] = 8'(16 + bp);
            end
            mrd(la[k], '{ex[k]}, "protected range");
         end
      end
      wsr(8'h00);
      mwr(1'b1, 16'hfffe, '{8'ha1, 8'ha2, 8'ha3});
      stat(s);
      chk("latch cleared by write", s, 8'h00);
      md = 1'b1;
      mrd(16'h7ffe, '{8'ha1, 8'ha2, 8'ha3}, "mode 3 wrapped read");
      md = 1'b0;
      mwr(1'b0, 16'h0000, '{8'h55});
      mrd(16'h0000, '{8'ha3}, "write without latch");
      wsr(8'hff);
      stat(s);
      chk("fixed bits and latch", s, 8'h8c);
      set_wp(1'b0);
      wsr(8'h00);
      stat(s);
      chk("status locked by pin", s, 8'h8c);
      set_wp(1'b1);
      op(OP_SET_WE);
      m.start(md);
      m.xfer(OP_WR_STATUS, r);
      set_wp(1'b0);
      m.xfer(8'h84, r);
      fin();
      stat(s);
      chk("pin change mid select", s, 8'h84);
      mwr(1'b1, 16'h0000, '{8'h77});
      mrd(16'h0000, '{8'h77}, "array write with pin low");
      mwr(1'b1, 16'h7fff, '{8'he1, 8'he2});
      m.start(md);
      m.xfer(OP_READ, r);
      m.xfer(8'h7f, r);
      m.xfer(8'hfe, r);
      m.xfer(8'h00, r);
      chk("read before pause", r, 8'ha1);
      m.hold(1'b1);
      chk("output floats paused", {7'h00, so_oe}, 8'h00);
      m.hold(1'b0);
      m.xfer(8'h00, r);
      chk("protected byte kept", r, 8'ha2);
      m.xfer(8'h00, r);
      chk("address advanced past drop", r, 8'he2);
      fin();
      report_and_stop();
   end
endmodule
